//--- acsr_apb.sv
`timescale 1ns/1ps
`default_nettype none

module acsr_apb (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic addr_hit,
  input wire logic [31:0] rd_data,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  output logic wr_stb
);
  import acsr_pkg::*;

  // Ready is raised for the access phase that follows each setup cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && !penable && !pready;
    end
  end

  // Read data and error are captured in the setup cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata <= (addr_hit && !pwrite) ? rd_data : 32'h0;
      pslverr <= !addr_hit;
    end
  end

  // A write takes effect only at the completing edge of a mapped access.
  assign wr_stb = psel && penable && pready && pwrite && addr_hit;

endmodule : acsr_apb

`default_nettype wire

//--- acsr_defs.svh
`ifndef ACSR_DEFS_SVH
`define ACSR_DEFS_SVH

// APB address decode width and register byte offsets.
`define ACSR_ADDR_W 12
`define ACSR_OFF_FLOW 12'h000
`define ACSR_OFF_CTRL 12'h004
`define ACSR_OFF_STAT 12'h008

// Flow control register bit positions.
`define ACSR_FLOW_ABORT 7
`define ACSR_FLOW_TRIGGER 6
`define ACSR_FLOW_RESTART 5
`define ACSR_FLOW_LOAD_OK 4

// Control register bit positions.
`define ACSR_CTRL_EN 0
`define ACSR_CTRL_DBUF 1
`define ACSR_CTRL_ACCESS_LO 2
`define ACSR_CTRL_ACCESS_HI 3
`define ACSR_CTRL_RMODE 4
`define ACSR_CTRL_SRST 5

// Bits of the access control field: bus access and internal interface access.
`define ACSR_ACCESS_BUS 0
`define ACSR_ACCESS_INT 1

// Status register bit positions.
`define ACSR_STAT_LOAD_ERR 0
`define ACSR_STAT_OVR_RESTART 1
`define ACSR_STAT_OVR_LOAD 2
`define ACSR_STAT_LIST 3
`define ACSR_STAT_BUSY 4

// Reset values.
`define ACSR_CTRL_RST 8'h00
`define ACSR_ACCESS_RST 2'h1

`endif

//--- acsr_far_model.sv
`timescale 1ns/1ps
`default_nettype none

module acsr_far_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic fetch_top,
  output wire acsr_pkg::acsr_conv_in_t conv_in,
  output wire acsr_pkg::acsr_trigger_flag_in_t trigger_flag_in
);
  import acsr_pkg::*;

  logic busy;
  logic loaded;
  logic eol_q;
  logic rst_q;
  logic ld_q;
  int lat;
  int cnt;

  // Idle defaults: the engine starts busy so requests can be held pending.
  initial begin
    busy = 1'b1;
    eol_q = 1'b0;
    rst_q = 1'b0;
    ld_q = 1'b1;
    lat = 2;
  end

  // The abort line is never raised by this model.
  assign conv_in = {busy, loaded, eol_q, 1'b0};
  assign trigger_flag_in = {rst_q, ld_q};

  // Engine answers a fetch with a load pulse after a settable latency.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      loaded <= 1'b0;
    end else begin
      loaded <= (cnt == 1);
      if (fetch_top === 1'b1) begin
        cnt <= lat;
      end else if (cnt != 0) begin
        cnt <= cnt - 1;
      end
    end
  end

  // One restart pulse; load-ready is valid only with it and inverted after.
  task restart(input logic ld);
    @(posedge pclk);
    rst_q <= 1'b1;
    ld_q <= ld;
    @(posedge pclk);
    rst_q <= 1'b0;
    ld_q <= ~ld;
  endtask : restart

  // One end-of-list pulse from the engine.
  task eol();
    @(posedge pclk);
    eol_q <= 1'b1;
    @(posedge pclk);
    eol_q <= 1'b0;
  endtask : eol
endmodule : acsr_far_model

`default_nettype wire

//--- acsr_pkg.sv
`default_nettype none

package acsr_pkg;

  // Restart sequencing states.
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_LOAD} acsr_state_t;

  // Status from the conversion engine.
  typedef struct packed {
    logic busy;
    logic cmd_loaded;
    logic end_of_list;
    logic seq_abort;
  } acsr_conv_in_t;

  // Requests from the trigger unit.
  typedef struct packed {
    logic restart;
    logic load_ready;
  } acsr_trigger_flag_in_t;

  // Control towards the conversion engine.
  typedef struct packed {
    logic fetch_top;
    logic active_list;
    logic restart_pending;
    logic trigger;
  } acsr_conv_out_t;

endpackage : acsr_pkg

`default_nettype wire

//--- acsr_restart_ctrl.sv
// Behaviour
// - A restart fetches the first command from the list top only when no conversion is running.
// - The restart flag clears once that first command is loaded into the command register.
// - Restart and load-ok flags can be set only while enabled and are cleared while disabled.
// - Writing zero to the restart or load-ok flag leaves it unchanged.
// - Writing one to the restart flag never clears it and counts as overrun if already set.
// - Under internal access a restart input sets the flag and a repeat while set is overrun.
// - In trigger mode the trigger flag sets with the restart flag after end-of-list or abort.
// - A set load-ok flag marks the alternative list ready and the lists swap at the next restart.
// - The load-ok flag clears when a restart executes with the list swap.
// - The load-ok flag is held at zero while double-buffer mode is off.
// - Writing one never clears a set load-ok flag; only a swap, disable, soft reset or double-buffer off does.
// - Under internal access load-ok is set only if load-ready is high as restart asserts.
// - In restart mode a restart without load-ok sets the load-ok error unless tied to an abort.
// - The first restart after enable, stop exit, soft reset or list swap raises no load-ok error.
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`include "acsr_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module acsr_restart_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`ACSR_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  input wire acsr_pkg::acsr_conv_in_t conv_in,
  input wire acsr_pkg::acsr_trigger_flag_in_t trigger_flag_in,
  input wire logic stop_mode,
  output acsr_pkg::acsr_conv_out_t conv_out
);
  import acsr_pkg::*;

  acsr_state_t state_r;
  logic en_r, dbuf_r, rmode_r, srst_r, en_d_r, stop_d_r;
  logic [1:0] access_r;
  logic restart_r, load_ok_r, trigger_r, fetch_r, list_r;
  logic eol_seen_r, abort_seen_r, abort_tag_r, exempt_r;
  logic load_err_r, ovr_restart_r, ovr_load_r;
  logic wr_stb, addr_hit, flow_wr, ctrl_wr, stat_wr;
  logic bus_ok, int_ok, bus_restart, int_restart, restart_req, load_req;
  logic abort_req, clr_all, fetch_now, restart_clr, swap_now, err_set;
  logic [31:0] rd_data;

  // Address decode of the three mapped words.
  assign addr_hit = (paddr == `ACSR_OFF_FLOW) || (paddr == `ACSR_OFF_CTRL) ||
                    (paddr == `ACSR_OFF_STAT);
  assign flow_wr = wr_stb && (paddr == `ACSR_OFF_FLOW);
  assign ctrl_wr = wr_stb && (paddr == `ACSR_OFF_CTRL);
  assign stat_wr = wr_stb && (paddr == `ACSR_OFF_STAT);

  // Request sources selected by the access control field.
  assign bus_ok = access_r[`ACSR_ACCESS_BUS];
  assign int_ok = access_r[`ACSR_ACCESS_INT];
  assign bus_restart = flow_wr && bus_ok && pwdata[`ACSR_FLOW_RESTART];
  assign int_restart = int_ok && trigger_flag_in.restart;
  assign restart_req = en_r && (bus_restart || int_restart);
  // Load-ok needs restart written with it, or load-ready sampled with the restart input.
  assign load_req = en_r && dbuf_r &&
                    ((bus_restart && pwdata[`ACSR_FLOW_LOAD_OK]) ||
                     (int_restart && trigger_flag_in.load_ready));
  assign abort_req = (flow_wr && bus_ok && pwdata[`ACSR_FLOW_ABORT]) || conv_in.seq_abort;

  // Disable and soft reset both wipe the pending flow flags.
  assign clr_all = !en_r || srst_r;
  assign fetch_now = (state_r == ST_WAIT) && !conv_in.busy && en_r;
  assign restart_clr = (state_r == ST_LOAD) && conv_in.cmd_loaded;
  assign swap_now = fetch_now && load_ok_r;
  assign err_set = fetch_now && rmode_r && !load_ok_r && !exempt_r && !abort_tag_r;

  // Bus slave front end.
  acsr_apb u_apb (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .addr_hit(addr_hit),
    .rd_data(rd_data),
    .pready(pready),
    .pslverr(pslverr),
    .prdata(prdata),
    .wr_stb(wr_stb)
  );

  // Read multiplexer; unused upper bits read as zero.
  always_comb begin
    rd_data = 32'h0;
    if (paddr == `ACSR_OFF_FLOW) begin
      rd_data[`ACSR_FLOW_TRIGGER] = trigger_r;
      rd_data[`ACSR_FLOW_RESTART] = restart_r;
      rd_data[`ACSR_FLOW_LOAD_OK] = load_ok_r;
    end else if (paddr == `ACSR_OFF_CTRL) begin
      rd_data[`ACSR_CTRL_EN] = en_r;
      rd_data[`ACSR_CTRL_DBUF] = dbuf_r;
      rd_data[`ACSR_CTRL_ACCESS_HI:`ACSR_CTRL_ACCESS_LO] = access_r;
      rd_data[`ACSR_CTRL_RMODE] = rmode_r;
    end else if (paddr == `ACSR_OFF_STAT) begin
      rd_data[`ACSR_STAT_LOAD_ERR] = load_err_r;
      rd_data[`ACSR_STAT_OVR_RESTART] = ovr_restart_r;
      rd_data[`ACSR_STAT_OVR_LOAD] = ovr_load_r;
      rd_data[`ACSR_STAT_LIST] = list_r;
      rd_data[`ACSR_STAT_BUSY] = (state_r != ST_IDLE);
    end
  end

  // Control register; the soft reset bit clears itself after one cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {rmode_r, dbuf_r, en_r} <= 3'h0;
      access_r <= `ACSR_ACCESS_RST;
      srst_r <= 1'b0;
    end else begin
      srst_r <= ctrl_wr && pwdata[`ACSR_CTRL_SRST];
      if (ctrl_wr) begin
        en_r <= pwdata[`ACSR_CTRL_EN];
        dbuf_r <= pwdata[`ACSR_CTRL_DBUF];
        access_r <= pwdata[`ACSR_CTRL_ACCESS_HI:`ACSR_CTRL_ACCESS_LO];
        rmode_r <= pwdata[`ACSR_CTRL_RMODE];
      end
    end
  end

  // Delayed copies for enable and stop-exit edge detection.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_d_r <= 1'b0;
      stop_d_r <= 1'b0;
    end else begin
      en_d_r <= en_r;
      stop_d_r <= stop_mode;
    end
  end

  // Restart sequencing: wait for idle, fetch from the top, wait for the load.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_IDLE;
    end else if (clr_all) begin
      state_r <= ST_IDLE;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (restart_req) begin
            state_r <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (fetch_now) begin
            state_r <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          if (restart_clr) begin
            state_r <= restart_req ? ST_WAIT : ST_IDLE;
          end
        end
      endcase
    end
  end

  // Restart flag; a new request in the clearing cycle keeps it set.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      restart_r <= 1'b0;
    end else if (clr_all) begin
      restart_r <= 1'b0;
    end else if (restart_req) begin
      restart_r <= 1'b1;
    end else if (restart_clr) begin
      restart_r <= 1'b0;
    end
  end

  // Fetch pulse towards the engine, one cycle per restart.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fetch_r <= 1'b0;
    end else begin
      fetch_r <= fetch_now;
    end
  end

  // Load-ok flag; only a swap, disable, soft reset or double-buffer off clears it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_ok_r <= 1'b0;
    end else if (clr_all || !dbuf_r) begin
      load_ok_r <= 1'b0;
    end else if (load_req) begin
      load_ok_r <= 1'b1;
    end else if (swap_now) begin
      load_ok_r <= 1'b0;
    end
  end

  // Active list index toggles at each swap.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      list_r <= 1'b0;
    end else if (swap_now) begin
      list_r <= !list_r;
    end
  end

  // End-of-list and abort history since the last fetch.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eol_seen_r <= 1'b0;
      abort_seen_r <= 1'b0;
    end else if (clr_all) begin
      eol_seen_r <= 1'b0;
      abort_seen_r <= 1'b0;
    end else begin
      eol_seen_r <= conv_in.end_of_list || (eol_seen_r && !fetch_now);
      abort_seen_r <= abort_req || (abort_seen_r && !fetch_now);
    end
  end

  // Marks a pending restart that followed or coincided with an abort.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      abort_tag_r <= 1'b0;
    end else if (clr_all) begin
      abort_tag_r <= 1'b0;
    end else if (restart_req && (!restart_r || restart_clr)) begin
      abort_tag_r <= abort_seen_r || abort_req;
    end else if (fetch_now) begin
      abort_tag_r <= 1'b0;
    end
  end

  // Trigger flag sets together with the restart flag in trigger mode after end-of-list or abort.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trigger_r <= 1'b0;
    end else if (clr_all) begin
      trigger_r <= 1'b0;
    end else if (restart_req && !rmode_r &&
                 (eol_seen_r || conv_in.end_of_list || abort_seen_r || abort_req)) begin
      trigger_r <= 1'b1;
    end else if (restart_clr) begin
      trigger_r <= 1'b0;
    end
  end

  // Exemption for the first restart after enable, stop exit, soft reset or swap.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exempt_r <= 1'b1;
    end else if ((en_r && !en_d_r) || (stop_d_r && !stop_mode) || srst_r || swap_now) begin
      exempt_r <= 1'b1;
    end else if (fetch_now) begin
      exempt_r <= 1'b0;
    end
  end

  // Sticky error flags; software clears with a one, a new event wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_err_r <= 1'b0;
      ovr_restart_r <= 1'b0;
      ovr_load_r <= 1'b0;
    end else begin
      if (err_set) begin
        load_err_r <= 1'b1;
      end else if (stat_wr && pwdata[`ACSR_STAT_LOAD_ERR]) begin
        load_err_r <= 1'b0;
      end
      if (restart_req && restart_r && !restart_clr) begin
        ovr_restart_r <= 1'b1;
      end else if (stat_wr && pwdata[`ACSR_STAT_OVR_RESTART]) begin
        ovr_restart_r <= 1'b0;
      end
      if (load_req && load_ok_r && !swap_now) begin
        ovr_load_r <= 1'b1;
      end else if (stat_wr && pwdata[`ACSR_STAT_OVR_LOAD]) begin
        ovr_load_r <= 1'b0;
      end
    end
  end

  // Engine-facing outputs, all from flip-flops.
  assign conv_out.fetch_top = fetch_r;
  assign conv_out.active_list = list_r;
  assign conv_out.restart_pending = restart_r;
  assign conv_out.trigger = trigger_r;

  // Checks on the flow flags.
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_restart_off_clear: assert property (!en_r |=> !restart_r && !load_ok_r)
    else $error("flow flag survived disable");
  a_load_ok_forced: assert property (!dbuf_r |=> !load_ok_r)
    else $error("load-ok set without double buffering");
  a_fetch_when_idle: assert property (fetch_r |-> $past(!conv_in.busy) && $past(restart_r))
    else $error("fetch issued while busy or without restart");
  a_clear_on_load: assert property (restart_clr && !restart_req && !clr_all |=> !restart_r)
    else $error("restart flag not cleared after load");
  a_zero_write_keeps: assert property (
    flow_wr && !pwdata[`ACSR_FLOW_RESTART] && restart_r && !restart_clr && !clr_all
    |=> restart_r)
    else $error("zero write cleared restart flag");
  a_overrun_flagged: assert property (restart_req && restart_r && !restart_clr && !clr_all
    |=> ovr_restart_r && restart_r)
    else $error("restart overrun not recorded");
  a_swap_clears_ok: assert property (swap_now && !load_req && !clr_all
    |=> !load_ok_r && (list_r != $past(list_r)) ##1 fetch_r == 1'b0)
    else $error("swap did not clear load-ok or toggle list");
  a_int_load_sample: assert property (
    int_restart && !trigger_flag_in.load_ready && !bus_restart && !load_ok_r |=> !load_ok_r)
    else $error("load-ok set without load-ready");
  a_load_err_set: assert property (err_set |=> load_err_r)
    else $error("load-ok error missed");
  a_exempt_no_err: assert property (fetch_now && exempt_r && !load_err_r && !stat_wr
    |=> !load_err_r)
    else $error("load-ok error on exempt restart");
  a_trigger_with_rst: assert property (restart_req && !clr_all && !rmode_r && abort_req
    |=> trigger_r && restart_r)
    else $error("trigger flag not set with restart");

endmodule : acsr_restart_ctrl

`default_nettype wire

//--- acsr_restart_ctrl_tb_top.sv
`include "acsr_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module acsr_restart_ctrl_tb_top;
  import acsr_pkg::*;

  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [`ACSR_ADDR_W-1:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] rq;
  logic pready;
  logic pslverr;
  logic rerr;
  logic stop_mode;
  acsr_conv_in_t conv_in;
  acsr_trigger_flag_in_t trigger_flag_in;
  acsr_conv_out_t conv_out;
  int fails;
  int num_checks;
  int fetches;

  acsr_restart_ctrl acsr_restart_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .conv_in(conv_in), .trigger_flag_in(trigger_flag_in),
    .stop_mode(stop_mode), .conv_out(conv_out));

  acsr_far_model acsr_far_model_i (.pclk(pclk), .presetn(presetn),
    .fetch_top(conv_out.fetch_top), .conv_in(conv_in), .trigger_flag_in(trigger_flag_in));

  // Clock at 250 MHz.
  always #2 pclk = ~pclk;

  // Counts fetch pulses towards the engine.
  always @(posedge pclk) begin
    if (conv_out.fetch_top === 1'b1) fetches++;
  end

  // Prints the counts and the verdict, then ends the run.
  task finish_test();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test

  // Compares a seen value against the expected one.
  task check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One APB transfer; holds the request until pready is sampled high.
  task bus(input logic wr, input logic [`ACSR_ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      fails++;
      finish_test();
    end
    rq = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : bus

  // Register write and masked register read.
  task wr(input logic [`ACSR_ADDR_W-1:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task rd(input logic [`ACSR_ADDR_W-1:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(rq & m, e);
  endtask : rd

  // Waits, bounded, until the pending restart has been served.
  task wait_clear();
    int n;
    n = 0;
    while (conv_out.restart_pending !== 1'b0 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    if (conv_out.restart_pending !== 1'b0) begin
      fails++;
      finish_test();
    end
  endtask : wait_clear

  // Main sequence of tests.
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    stop_mode = 1'b0;
    fails = 0;
    num_checks = 0;
    fetches = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(`ACSR_OFF_FLOW, 32'hFF, 32'h00);
    rd(`ACSR_OFF_CTRL, 32'hFF, 32'h04);
    rd(`ACSR_OFF_STAT, 32'h0F, 32'h00);
    bus(1'b0, 12'h00C, 32'h0);
    check({31'h0, rerr}, 32'h1);
    wr(`ACSR_OFF_FLOW, 32'h30);
    rd(`ACSR_OFF_FLOW, 32'hFF, 32'h00);
    $display("test reset and disabled done");
    wr(`ACSR_OFF_CTRL, 32'h17);
    wr(`ACSR_OFF_FLOW, 32'h30);
    rd(`ACSR_OFF_FLOW, 32'hFF, 32'h30);
    wr(`ACSR_OFF_FLOW, 32'h00);
    rd(`ACSR_OFF_FLOW, 32'hFF, 32'h30);
    wr(`ACSR_OFF_FLOW, 32'h30);
    rd(`ACSR_OFF_FLOW, 32'hFF, 32'h30);
    rd(`ACSR_OFF_STAT, 32'h0F, 32'h06);
    repeat (8) @(posedge pclk);
    check(fetches, 32'd0);
    acsr_far_model_i.busy <= 1'b0;
    wait_clear();
    check(fetches, 32'd1);
    check({31'h0, conv_out.active_list}, 32'h1);
    rd(`ACSR_OFF_FLOW, 32'hFF, 32'h00);
    rd(`ACSR_OFF_STAT, 32'h0F, 32'h0E);
    $display("test bus restart with swap done");
    wr(`ACSR_OFF_STAT, 32'h07);
    acsr_far_model_i.lat = 6;
    wr(`ACSR_OFF_FLOW, 32'h20);
    wait_clear();
    rd(`ACSR_OFF_STAT, 32'h0F, 32'h08);
    wr(`ACSR_OFF_FLOW, 32'h20);
    wait_clear();
    rd(`ACSR_OFF_STAT, 32'h0F, 32'h09);
    $display("test load error done");
    acsr_far_model_i.busy <= 1'b1;
    wr(`ACSR_OFF_STAT, 32'h07);
    wr(`ACSR_OFF_CTRL, 32'h05);
    wr(`ACSR_OFF_FLOW, 32'h30);
    rd(`ACSR_OFF_FLOW, 32'hFF, 32'h20);
    wr(`ACSR_OFF_CTRL, 32'h04);
    rd(`ACSR_OFF_FLOW, 32'hFF, 32'h00);
    $display("test single buffer and disable done");
    wr(`ACSR_OFF_CTRL, 32'h0B);
    acsr_far_model_i.eol();
    acsr_far_model_i.restart(1'b1);
    @(posedge pclk);
    check({31'h0, conv_out.restart_pending}, 32'h1);
    check({31'h0, conv_out.trigger}, 32'h1);
    rd(`ACSR_OFF_FLOW, 32'hFF, 32'h70);
    acsr_far_model_i.restart(1'b0);
    rd(`ACSR_OFF_STAT, 32'h0F, 32'h0A);
    acsr_far_model_i.busy <= 1'b0;
    wait_clear();
    rd(`ACSR_OFF_FLOW, 32'hFF, 32'h00);
    rd(`ACSR_OFF_STAT, 32'h08, 32'h00);
    acsr_far_model_i.busy <= 1'b1;
    acsr_far_model_i.restart(1'b0);
    rd(`ACSR_OFF_FLOW, 32'hFF, 32'h20);
    $display("test internal interface done");
    // Bus access in trigger mode: a restart written together with an abort sets the trigger flag.
    wr(`ACSR_OFF_CTRL, 32'h04);
    wr(`ACSR_OFF_CTRL, 32'h05);
    wr(`ACSR_OFF_FLOW, 32'hA0);
    rd(`ACSR_OFF_FLOW, 32'hFF, 32'h60);
    acsr_far_model_i.busy <= 1'b0;
    wait_clear();
    rd(`ACSR_OFF_FLOW, 32'hFF, 32'h00);
    // Restart mode: a restart tied to an abort raises no load-ok error.
    wr(`ACSR_OFF_CTRL, 32'h15);
    wr(`ACSR_OFF_FLOW, 32'hA0);
    wait_clear();
    rd(`ACSR_OFF_STAT, 32'h01, 32'h00);
    // A stop exit re-arms the exemption for the next restart.
    stop_mode <= 1'b1;
    @(posedge pclk);
    stop_mode <= 1'b0;
    wr(`ACSR_OFF_FLOW, 32'h20);
    wait_clear();
    rd(`ACSR_OFF_STAT, 32'h01, 32'h00);
    // A soft reset re-arms it too; the restart after that one is an error again.
    wr(`ACSR_OFF_CTRL, 32'h35);
    rd(`ACSR_OFF_CTRL, 32'hFF, 32'h15);
    wr(`ACSR_OFF_FLOW, 32'h20);
    wait_clear();
    rd(`ACSR_OFF_STAT, 32'h01, 32'h00);
    wr(`ACSR_OFF_FLOW, 32'h20);
    wait_clear();
    rd(`ACSR_OFF_STAT, 32'h01, 32'h01);
    check({31'h0, conv_out.active_list}, 32'h0);
    $display("test abort and exemptions done");
    finish_test();
  end
endmodule : acsr_restart_ctrl_tb_top

`default_nettype wire
